// ### verilog/motion_link_sequencer.sv
// Purpose: Arms activity and inactivity detection, tracks awake state, drives interrupt pins.
// Assumes: Detector inputs are one-cycle pulses synchronous to i_clk_sys.
// Notes:   Registers reached over AXI4-Lite; one write and one read in flight.
`timescale 1ns/1ps
`include "motion_link_params.svh"

module motion_link_sequencer
  import motion_link_pkg::*;
(
  input  wire logic                     i_clk_sys,
  input  wire logic                     i_reset,
  input  wire logic [`MLS_ADDR_W-1:0]   i_s_axi_awaddr,
  input  wire logic                     i_s_axi_awvalid,
  output logic                          o_s_axi_awready,
  input  wire logic [`MLS_DATA_W-1:0]   i_s_axi_wdata,
  input  wire logic [3:0]               i_s_axi_wstrb,
  input  wire logic                     i_s_axi_wvalid,
  output logic                          o_s_axi_wready,
  output logic [1:0]                    o_s_axi_bresp,
  output logic                          o_s_axi_bvalid,
  input  wire logic                     i_s_axi_bready,
  input  wire logic [`MLS_ADDR_W-1:0]   i_s_axi_araddr,
  input  wire logic                     i_s_axi_arvalid,
  output logic                          o_s_axi_arready,
  output logic [`MLS_DATA_W-1:0]        o_s_axi_rdata,
  output logic [1:0]                    o_s_axi_rresp,
  output logic                          o_s_axi_rvalid,
  input  wire logic                     i_s_axi_rready,
  input  wire logic                     i_sample_strobe,
  input  wire logic                     i_act_timed,
  input  wire logic                     i_act_single,
  input  wire logic                     i_inact_detect,
  output logic                          o_act_armed,
  output logic                          o_inact_armed,
  output logic                          o_act_ref_load,
  output logic                          o_wakeup_mode,
  output logic                          o_awake,
  output logic                          o_interrupt_pin_one,
  output logic                          o_interrupt_pin_two,
  output logic                          o_fifo_frozen
);

  // Map the control field onto a link behaviour
  function automatic link_t decode_link(input logic [1:0] code);
    link_t res;
    res = link_default;
    if (code == `MLS_MODE_LINKED) begin
      res = link_linked;
    end else if (code == `MLS_MODE_LOOP) begin
      res = link_loop;
    end
    return res;
  endfunction

  // Register address match, used by both write and read paths
  function automatic logic addr_is(input logic [`MLS_ADDR_W-1:0] a,
                                   input logic [`MLS_ADDR_W-1:0] ofs);
    return a[`MLS_ADDR_W-1:2] == ofs[`MLS_ADDR_W-1:2];
  endfunction

  // Bus slave state
  logic                       aw_held;
  logic                       next_aw_held;
  logic [`MLS_ADDR_W-1:0]     aw_addr;
  logic [`MLS_ADDR_W-1:0]     next_aw_addr;
  logic                       w_held;
  logic                       next_w_held;
  logic [`MLS_DATA_W-1:0]     w_data;
  logic [`MLS_DATA_W-1:0]     next_w_data;
  logic [3:0]                 w_strb;
  logic [3:0]                 next_w_strb;
  logic                       bvalid;
  logic                       next_bvalid;
  logic [1:0]                 bresp;
  logic [1:0]                 next_bresp;
  logic                       rvalid;
  logic                       next_rvalid;
  logic [1:0]                 rresp;
  logic [1:0]                 next_rresp;
  logic [`MLS_DATA_W-1:0]     rdata;
  logic [`MLS_DATA_W-1:0]     next_rdata;
  logic                       do_write;
  logic                       rd_take;

  // Software-visible configuration
  logic [`MLS_CTRL_W-1:0]     ctrl;
  logic [`MLS_CTRL_W-1:0]     next_ctrl;
  logic [`MLS_ROUTE_W-1:0]    route;
  logic [`MLS_ROUTE_W-1:0]    next_route;

  // Sequencer state
  phase_t                     phase;
  phase_t                     next_phase;
  logic                       act_pend;
  logic                       next_act_pend;
  logic                       inact_pend;
  logic                       next_inact_pend;
  logic                       next_act_armed;
  logic                       next_inact_armed;
  logic                       next_ref_load;
  logic                       next_wakeup;
  logic                       next_awake;
  logic                       next_pin_one;
  logic                       next_pin_two;
  logic                       next_frozen;
  logic [`MLS_FIFO_CNT_W-1:0] fifo_cnt;
  logic [`MLS_FIFO_CNT_W-1:0] next_fifo_cnt;

  // Decoded events and controls
  link_t                      link;
  logic                       act_evt;
  logic                       inact_evt;
  logic                       status_read;
  logic                       freeze_release;
  logic                       gate_ok;

  // Handshake outputs; one write and one read are accepted at a time
  assign o_s_axi_awready = !aw_held && !bvalid;
  assign o_s_axi_wready  = !w_held && !bvalid;
  assign o_s_axi_arready = !rvalid;
  assign o_s_axi_bvalid  = bvalid;
  assign o_s_axi_bresp   = bresp;
  assign o_s_axi_rvalid  = rvalid;
  assign o_s_axi_rresp   = rresp;
  assign o_s_axi_rdata   = rdata;
  assign do_write        = aw_held && w_held && !bvalid;
  assign rd_take         = i_s_axi_arvalid && !rvalid;

  // Bus write and read channels; address and data may arrive in either order
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    if (i_s_axi_awvalid && o_s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && o_s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = i_s_axi_wdata;
      next_w_strb = i_s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (addr_is(aw_addr, `MLS_OFS_CTRL) || addr_is(aw_addr, `MLS_OFS_ROUTE)
                     || addr_is(aw_addr, `MLS_OFS_FREEZE) || addr_is(aw_addr, `MLS_OFS_STATUS))
                     ? `MLS_RESP_OKAY : `MLS_RESP_SLVERR;
    end else if (bvalid && i_s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (rd_take) begin
      next_rvalid = 1'b1;
      next_rresp  = `MLS_RESP_OKAY;
      next_rdata  = '0;
      if (addr_is(i_s_axi_araddr, `MLS_OFS_CTRL)) begin
        next_rdata[`MLS_CTRL_W-1:0] = ctrl;
      end else if (addr_is(i_s_axi_araddr, `MLS_OFS_ROUTE)) begin
        next_rdata[`MLS_ROUTE_W-1:0] = route;
      end else if (addr_is(i_s_axi_araddr, `MLS_OFS_STATUS)) begin
        next_rdata[`MLS_ST_ACT_PEND]    = act_pend;
        next_rdata[`MLS_ST_INACT_PEND]  = inact_pend;
        next_rdata[`MLS_ST_AWAKE]       = o_awake;
        next_rdata[`MLS_ST_ACT_ARMED]   = o_act_armed;
        next_rdata[`MLS_ST_INACT_ARMED] = o_inact_armed;
        next_rdata[`MLS_ST_WAKEUP]      = o_wakeup_mode;
        next_rdata[`MLS_ST_FROZEN]      = o_fifo_frozen;
        next_rdata[`MLS_ST_COUNT_LO +: `MLS_FIFO_CNT_W] = fifo_cnt;
      end else if (!addr_is(i_s_axi_araddr, `MLS_OFS_FREEZE)) begin
        next_rresp = `MLS_RESP_SLVERR;
      end
    end else if (rvalid && i_s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held  <= 1'b0;
      w_data  <= '0;
      w_strb  <= '0;
      bvalid  <= 1'b0;
      bresp   <= `MLS_RESP_OKAY;
      rvalid  <= 1'b0;
      rresp   <= `MLS_RESP_OKAY;
      rdata   <= '0;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rresp   <= next_rresp;
      rdata   <= next_rdata;
    end
  end

  // Configuration writes; all fields sit in byte lane 0
  always_comb begin
    next_ctrl  = ctrl;
    next_route = route;
    if (do_write && w_strb[0]) begin
      if (addr_is(aw_addr, `MLS_OFS_CTRL)) begin
        next_ctrl = w_data[`MLS_CTRL_W-1:0];
      end
      if (addr_is(aw_addr, `MLS_OFS_ROUTE)) begin
        next_route = w_data[`MLS_ROUTE_W-1:0];
      end
    end
  end

  // Both enables reset to zero so nothing fires before software opts in
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      ctrl  <= `MLS_CTRL_RESET;
      route <= `MLS_ROUTE_RESET;
    end else begin
      ctrl  <= next_ctrl;
      route <= next_route;
    end
  end

  // Event qualification; the timed activity path only counts in measurement mode
  assign link      = decode_link(ctrl[`MLS_CTRL_MODE_HI:`MLS_CTRL_MODE_LO]);
  assign act_evt   = o_act_armed && (o_wakeup_mode ? i_act_single : i_act_timed);
  assign inact_evt = o_inact_armed && i_inact_detect;
  assign status_read    = rd_take && addr_is(i_s_axi_araddr, `MLS_OFS_STATUS);
  assign freeze_release = do_write && w_strb[0] && addr_is(aw_addr, `MLS_OFS_FREEZE)
                          && w_data[`MLS_FREEZE_RELEASE];

  // Sequencer next state
  always_comb begin
    next_phase      = phase;
    next_awake      = o_awake;
    next_wakeup     = o_wakeup_mode;
    next_act_armed  = 1'b0;
    next_inact_armed = 1'b0;
    gate_ok         = 1'b1;
    // Pending flags: a new event wins over a same-cycle status read;
    // in loop mode a flag lives one cycle, so no read is needed
    next_act_pend   = act_evt || (act_pend && !status_read && link != link_loop);
    next_inact_pend = inact_evt || (inact_pend && !status_read && link != link_loop);
    if (act_evt) begin
      next_awake = 1'b1;
    end else if (inact_evt) begin
      next_awake = 1'b0;
    end
    unique case (link)
      link_default: begin
        // Restart still, so a later switch to linked arms activity first
        next_phase       = phase_still;
        next_wakeup      = ctrl[`MLS_CTRL_HOST_WAKE];
        next_act_armed   = ctrl[`MLS_CTRL_ACT_EN] && !next_act_pend;
        next_inact_armed = ctrl[`MLS_CTRL_INACT_EN] && !next_inact_pend;
      end
      link_linked, link_loop: begin
        if (act_evt) begin
          next_phase = phase_moving;
        end else if (inact_evt) begin
          next_phase = phase_still;
        end
        if (ctrl[`MLS_CTRL_AUTOSLEEP]) begin
          if (inact_evt) begin
            next_wakeup = 1'b1;
          end else if (act_evt) begin
            next_wakeup = 1'b0;
          end
        end else begin
          next_wakeup = ctrl[`MLS_CTRL_HOST_WAKE];
        end
        // Linked mode holds the next detector off until the host has read
        if (link == link_linked) begin
          gate_ok = !next_act_pend && !next_inact_pend;
        end
        // Only the detector matching the phase is armed
        next_act_armed   = ctrl[`MLS_CTRL_ACT_EN] && gate_ok
                           && next_phase == phase_still;
        next_inact_armed = ctrl[`MLS_CTRL_INACT_EN] && gate_ok
                           && next_phase == phase_moving;
      end
    endcase
    // Reference is taken whenever activity detection starts again
    next_ref_load = next_act_armed && !o_act_armed;
    // Pins from the next state, registered so they never glitch
    next_pin_one = (route[`MLS_ROUTE_AWAKE_P1] && next_awake)
                   || (route[`MLS_ROUTE_ACT_P1] && next_act_pend)
                   || (route[`MLS_ROUTE_INACT_P1] && next_inact_pend);
    next_pin_two = (route[`MLS_ROUTE_AWAKE_P2] && next_awake)
                   || (route[`MLS_ROUTE_ACT_P2] && next_act_pend)
                   || (route[`MLS_ROUTE_INACT_P2] && next_inact_pend);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      phase               <= phase_still;
      act_pend            <= 1'b0;
      inact_pend          <= 1'b0;
      o_act_armed         <= 1'b0;
      o_inact_armed       <= 1'b0;
      o_act_ref_load      <= 1'b0;
      o_wakeup_mode       <= 1'b0;
      o_awake             <= 1'b0;
      o_interrupt_pin_one <= 1'b0;
      o_interrupt_pin_two <= 1'b0;
    end else begin
      phase               <= next_phase;
      act_pend            <= next_act_pend;
      inact_pend          <= next_inact_pend;
      o_act_armed         <= next_act_armed;
      o_inact_armed       <= next_inact_armed;
      o_act_ref_load      <= next_ref_load;
      o_wakeup_mode       <= next_wakeup;
      o_awake             <= next_awake;
      o_interrupt_pin_one <= next_pin_one;
      o_interrupt_pin_two <= next_pin_two;
    end
  end

  // Pre-event history: counts stored samples, saturating at the buffer size.
  // The freeze wins over a same-cycle release so a trigger is never lost.
  // A release restarts the count from zero; a sample alongside is counted only if the history was not frozen.
  always_comb begin
    next_frozen   = o_fifo_frozen;
    next_fifo_cnt = fifo_cnt;
    if (freeze_release) begin
      next_frozen   = 1'b0;
      next_fifo_cnt = '0;
    end
    if (act_evt && ctrl[`MLS_CTRL_FIFO_TRIG]) begin
      next_frozen = 1'b1;
    end else if (!o_fifo_frozen && i_sample_strobe && next_fifo_cnt != `MLS_FIFO_DEPTH) begin
      next_fifo_cnt = next_fifo_cnt + 10'd1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_fifo_frozen <= 1'b0;
      fifo_cnt      <= '0;
    end else begin
      o_fifo_frozen <= next_frozen;
      fifo_cnt      <= next_fifo_cnt;
    end
  end

endmodule

// ### verilog/motion_link_params.svh
// Purpose: Offsets, field positions, reset values and sizes for the motion link sequencer.
// Assumes: AXI4-Lite register access, 32-bit data, byte addresses.
// Notes:   Definitions only.
`ifndef MOTION_LINK_PARAMS_SVH
`define MOTION_LINK_PARAMS_SVH

`define MLS_ADDR_W       8
`define MLS_DATA_W       32

// Register byte addresses
`define MLS_OFS_CTRL     8'h00
`define MLS_OFS_ROUTE    8'h04
`define MLS_OFS_STATUS   8'h08
`define MLS_OFS_FREEZE   8'h0c

// Control register fields
`define MLS_CTRL_ACT_EN     0
`define MLS_CTRL_INACT_EN   1
`define MLS_CTRL_MODE_LO    2
`define MLS_CTRL_MODE_HI    3
`define MLS_CTRL_AUTOSLEEP  4
`define MLS_CTRL_FIFO_TRIG  5
`define MLS_CTRL_HOST_WAKE  6
`define MLS_CTRL_W          7
`define MLS_CTRL_RESET      7'h00

// Link mode field codes; 2'b10 behaves as default
`define MLS_MODE_DEFAULT    2'h0
`define MLS_MODE_LINKED     2'h1
`define MLS_MODE_LOOP       2'h3

// Interrupt routing fields
`define MLS_ROUTE_AWAKE_P1  0
`define MLS_ROUTE_ACT_P1    1
`define MLS_ROUTE_INACT_P1  2
`define MLS_ROUTE_AWAKE_P2  3
`define MLS_ROUTE_ACT_P2    4
`define MLS_ROUTE_INACT_P2  5
`define MLS_ROUTE_W         6
`define MLS_ROUTE_RESET     6'h00

// Status register fields
`define MLS_ST_ACT_PEND     0
`define MLS_ST_INACT_PEND   1
`define MLS_ST_AWAKE        2
`define MLS_ST_ACT_ARMED    3
`define MLS_ST_INACT_ARMED  4
`define MLS_ST_WAKEUP       5
`define MLS_ST_FROZEN       6
`define MLS_ST_COUNT_LO     16

// Freeze release register field
`define MLS_FREEZE_RELEASE  0

// Sample history size
`define MLS_FIFO_DEPTH      10'd512
`define MLS_FIFO_CNT_W      10

// AXI responses
`define MLS_RESP_OKAY       2'h0
`define MLS_RESP_SLVERR     2'h2

`endif

// ### verilog/motion_link_pkg.sv
// Purpose: Types shared by the motion link sequencer.
// Assumes: Constants live in motion_link_params.svh.
// Notes:   Types only.
package motion_link_pkg;

  // Whether the sequencer regards the device as still or moving
  typedef enum logic {
    phase_still,
    phase_moving
  } phase_t;

  // Decoded link behaviour
  typedef enum logic [1:0] {
    link_default,
    link_linked,
    link_loop
  } link_t;

endpackage

// ### verif/motion_front_end_model.sv
// Purpose: Detector front end model that sends motion event pulses and sample strobes.
// Assumes: The bench raises each request for one cycle.
// Notes:   Outputs are registered, so a pulse never straddles an edge.
`timescale 1ns/1ps
module motion_front_end_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset,
  input  wire logic       i_act_req,
  input  wire logic       i_inact_req,
  input  wire logic       i_single_req,
  input  wire logic       i_burst_go,
  input  wire logic [9:0] i_burst_len,
  output logic            o_act_pulse,
  output logic            o_inact_pulse,
  output logic            o_single_pulse,
  output logic            o_strobe
);
  logic [9:0] left;

  // A burst sends one strobe a cycle; a new burst restarts the count
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      left <= 10'h000;
    end else if (i_burst_go) begin
      left <= i_burst_len;
    end else if (left != 10'h000) begin
      left <= left - 10'h001;
    end
    o_act_pulse   <= i_act_req;
    o_inact_pulse <= i_inact_req;
    // Timed activity always implies a single qualifying sample, not the reverse
    o_single_pulse <= i_act_req | i_single_req;
    o_strobe      <= (left != 10'h000);
  end
endmodule

// ### verif/motion_link_sequencer_props.sv
// Purpose: Port-level checks for the motion link sequencer.
// Assumes: One clock domain; reset synchronous, active high.
// Notes:   Bound below to every sequencer instance.
`timescale 1ns/1ps
module motion_link_sequencer_props (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_rvalid,
  input wire logic i_act_timed,
  input wire logic i_act_single,
  input wire logic i_inact_detect,
  input wire logic o_act_armed,
  input wire logic o_inact_armed,
  input wire logic o_act_ref_load,
  input wire logic o_wakeup_mode,
  input wire logic o_awake,
  input wire logic o_fifo_frozen
);
  logic act_ev;

  // Activity counts only while armed; wake-up mode has no duration timer
  assign act_ev = o_act_armed && (o_wakeup_mode ? i_act_single : i_act_timed);

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  chk_reset_idle: assert property (
    $fell(i_reset) |-> !o_act_armed && !o_inact_armed && !o_awake)
    else $error("armed or awake just after reset");
  chk_act_disarm: assert property (
    act_ev |=> !o_act_armed)
    else $error("activity still armed after its event");
  chk_awake_set: assert property (
    act_ev |=> o_awake)
    else $error("awake not set by activity");
  chk_awake_clear: assert property (
    i_inact_detect && o_inact_armed && !act_ev |=> !o_awake)
    else $error("awake not cleared by inactivity");
  chk_awake_cause: assert property (
    $rose(o_awake) |-> $past(act_ev))
    else $error("awake rose without activity");
  chk_freeze_cause: assert property (
    $rose(o_fifo_frozen) |-> $past(act_ev))
    else $error("history froze without activity");
  chk_ref_on_arm: assert property (
    o_act_ref_load == $rose(o_act_armed))
    else $error("reference load not tied to arming");
  chk_wake_single: assert property (
    o_wakeup_mode && o_act_armed && i_act_single |=> o_awake)
    else $error("single sample ignored in wake-up mode");
  chk_read_answer: assert property (
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
    else $error("read data late");

  // Main scenarios reached
  cov_act: cover property (act_ev);
  cov_sleep: cover property ($fell(o_awake));
  cov_freeze: cover property ($rose(o_fifo_frozen));
endmodule

bind motion_link_sequencer motion_link_sequencer_props props (
  .i_clk_sys       (i_clk_sys),
  .i_reset         (i_reset),
  .i_s_axi_arvalid (i_s_axi_arvalid),
  .o_s_axi_arready (o_s_axi_arready),
  .o_s_axi_rvalid  (o_s_axi_rvalid),
  .i_act_timed     (i_act_timed),
  .i_act_single    (i_act_single),
  .i_inact_detect  (i_inact_detect),
  .o_act_armed     (o_act_armed),
  .o_inact_armed   (o_inact_armed),
  .o_act_ref_load  (o_act_ref_load),
  .o_wakeup_mode   (o_wakeup_mode),
  .o_awake         (o_awake),
  .o_fifo_frozen   (o_fifo_frozen)
);

// ### verif/motion_link_sequencer_bench.sv
// Purpose: Self-checking bench for the motion link sequencer.
// Assumes: Bus tasks run one at a time, starting just after a rising edge.
// Notes:   Expected responses are queued at issue and compared by a monitor.
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin n_checks++; if ((sn) !== (ex)) begin num_errors++; \
  $display("[FAIL] %s exp %h got %h", nm, ex, sn); end end
module motion_link_sequencer_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        act_req = 1'b0;
  logic        inact_req = 1'b0;
  logic        single_req = 1'b0;
  logic        go = 1'b0;
  logic [9:0]  blen = 10'h000;
  logic [9:0]  nb;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        act_p, inact_p, single_p, strobe, act_armed, inact_armed, ref_load;
  logic        wakeup, awake, pin1, pin2, frozen;
  logic [33:0] eq[$];
  logic [33:0] e;
  int          num_errors = 0;
  int          n_checks = 0;

  // System clock, 4 ns period
  always #2 clk = ~clk;

  motion_front_end_model fe (.i_clk_sys(clk), .i_reset(rst), .i_act_req(act_req),
    .i_inact_req(inact_req), .i_single_req(single_req), .i_burst_go(go),
    .i_burst_len(blen), .o_act_pulse(act_p), .o_inact_pulse(inact_p),
    .o_single_pulse(single_p), .o_strobe(strobe));

  // A full activity pulse drives both qualifiers; a single-sample pulse tests the power mode
  motion_link_sequencer dut (.i_clk_sys(clk), .i_reset(rst),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
    .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hf), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_sample_strobe(strobe),
    .i_act_timed(act_p), .i_act_single(single_p), .i_inact_detect(inact_p),
    .o_act_armed(act_armed), .o_inact_armed(inact_armed), .o_act_ref_load(ref_load),
    .o_wakeup_mode(wakeup), .o_awake(awake), .o_interrupt_pin_one(pin1),
    .o_interrupt_pin_two(pin2), .o_fifo_frozen(frozen));

  task automatic wrap_up;
    if (num_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Write: address and data offered together, each released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    logic da, dw, ah, wh, hb;
    da = 1'b0;
    dw = 1'b0;
    hb = 1'b0;
    eq.push_back({r, 32'h0});
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(da && dw)) begin
      @(negedge clk);
      ah = !da && awready;
      wh = !dw && wready;
      @(posedge clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      da = da | ah;
      dw = dw | wh;
    end
    while (!hb) begin
      @(negedge clk);
      hb = bvalid;
      @(posedge clk);
    end
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    logic ha, hr;
    ha = 1'b0;
    hr = 1'b0;
    eq.push_back({r, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!ha) begin
      @(negedge clk);
      ha = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    while (!hr) begin
      @(negedge clk);
      hr = rvalid;
      @(posedge clk);
    end
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // One event pulse, then time for the sequencer to settle
  task automatic ev(input logic a, input logic i, input logic s = 1'b0);
    act_req <= a;
    inact_req <= i;
    single_req <= s;
    @(posedge clk);
    act_req <= 1'b0;
    inact_req <= 1'b0;
    single_req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic bu(input logic [9:0] k);
    blen <= k;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (k + 3) @(posedge clk);
  endtask

  // Monitor takes the oldest note whenever a response is handed over
  always @(posedge clk) begin
    if ((bvalid & bready) === 1'b1) begin
      e = eq.pop_front();
      `CHK("bresp", e[33:32], bresp)
    end
    if ((rvalid & rready) === 1'b1) begin
      e = eq.pop_front();
      `CHK("rresp", e[33:32], rresp)
      `CHK("rdata", e[31:0], rdata)
    end
  end

  // Watchdog: the tests need about 800 cycles
  initial begin
    repeat (8000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h270e));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(8'h08, 32'h0);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h10, 32'h0, 2'h2);
    wr(8'h10, 32'h1, 2'h2);
    wr(8'h08, 32'hff);
    rd(8'h0c, 32'h0);
    // Default mode, autosleep set but ignored; second activity blocked by pending
    wr(8'h00, 32'h13);
    rd(8'h08, 32'h18);
    wr(8'h04, 32'h22);
    ev(1'b0, 1'b0, 1'b1);
    `CHK("pins", 2'b00, {pin1, pin2})
    ev(1'b1, 1'b0);
    `CHK("pins", 2'b10, {pin1, pin2})
    ev(1'b0, 1'b1);
    `CHK("pins", 2'b11, {pin1, pin2})
    ev(1'b1, 1'b0);
    rd(8'h08, 32'h03);
    `CHK("pins", 2'b00, {pin1, pin2})
    rd(8'h08, 32'h18);
    wr(8'h00, 32'h1b);
    rd(8'h08, 32'h18);
    // Linked mode entered from default
    wr(8'h00, 32'h07);
    rd(8'h08, 32'h08);
    ev(1'b1, 1'b0);
    rd(8'h08, 32'h05);
    rd(8'h08, 32'h14);
    wr(8'h00, 32'h17);
    ev(1'b1, 1'b0);
    ev(1'b0, 1'b1);
    rd(8'h08, 32'h22);
    rd(8'h08, 32'h28);
    ev(1'b0, 1'b0, 1'b1);
    rd(8'h08, 32'h05);
    rd(8'h08, 32'h14);
    ev(1'b0, 1'b1);
    rd(8'h08, 32'h22);
    rd(8'h08, 32'h28);
    // Loop mode with awake routed to both pins
    wr(8'h04, 32'h09);
    wr(8'h00, 32'h1f);
    `CHK("pins", 2'b00, {pin1, pin2})
    ev(1'b1, 1'b0);
    `CHK("pins", 2'b11, {pin1, pin2})
    rd(8'h08, 32'h14);
    ev(1'b0, 1'b1);
    `CHK("pins", 2'b00, {pin1, pin2})
    rd(8'h08, 32'h28);
    // Trigger mode history: saturation, then freeze on activity
    wr(8'h00, 32'h3f);
    bu(10'd600);
    rd(8'h08, 32'h0200_0028);
    wr(8'h0c, 32'h1);
    nb = 10'($urandom_range(20, 1));
    bu(nb);
    ev(1'b1, 1'b0);
    bu(10'd5);
    rd(8'h08, {6'h00, nb, 16'h0054});
    wr(8'h0c, 32'h1);
    rd(8'h08, 32'h14);
    wrap_up();
  end
endmodule
